// ==== inc/sport_map.svh ====
// register map, field positions, reset values and timing counts of the port
// assumes a byte-addressed 8-bit register address and 32-bit register data
`ifndef SPORT_MAP_SVH
`define SPORT_MAP_SVH

// register byte offsets
`define SP_OFF_RX_DATA 8'h00
`define SP_OFF_TX_DATA 8'h04
`define SP_OFF_CTRL 8'h08
`define SP_OFF_RATE 8'h14

// port control register fields
`define SP_CTL_RX_EN 0
`define SP_CTL_RX_RDY 1
`define SP_CTL_RX_ERR 3
`define SP_CTL_RX_MODE 5:4
`define SP_CTL_TX_EN 16
`define SP_CTL_TX_RDY 17
`define SP_CTL_TX_ERR 19
`define SP_CTL_TX_MODE 21:20
`define SP_CTL_GEN_EN 22
`define SP_CTL_MASTER 24

// rate generator register fields
`define SP_RATE_DIV 7:0
`define SP_RATE_SRC 29

// reset values
`define SP_DIV_RST 8'h01
`define SP_SRC_RST 1'b0

// bit clocks after the first transmitter enable in which a sync is spurious
`define SP_SETTLE_BCLK 2'h2

`endif

// ==== inc/sport_pkg.sv ====
// types shared by the serial port ready and event logic
// assumes the map header is included by the modules that need offsets
package sport_pkg;

  // interrupt source selection per section
  typedef enum logic [1:0] {
    IRQ_READY = 2'b00,
    IRQ_RSVD = 2'b01,
    IRQ_FSYNC = 2'b10,
    IRQ_SYNCERR = 2'b11
  } irq_mode_type;

  // element shifter state
  typedef enum logic {
    SH_IDLE = 1'b0,
    SH_BUSY = 1'b1
  } shift_state_type;

endpackage : sport_pkg

// ==== hdl/sport_rate_gen.sv ====
// bit clock generator: divides a source tick stream by divide + 1
// assumes src_tick_in is a one-cycle pulse per source clock rising edge
module sport_rate_gen #(
  parameter int DIV_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [DIV_W-1:0] divide_in,
  input wire logic src_tick_in,
  output logic gen_clk_out,
  output logic gen_rise_out
);

  logic [DIV_W-1:0] cnt_r, cnt_nxt;
  logic clk_r, clk_nxt;
  logic started_r, started_nxt;
  logic rise_r, rise_nxt;
  logic [DIV_W-1:0] hi_len;

  // high phase is the rounded-up half period; divide 0 leaves it steady high
  // because one sample per source edge cannot toggle at the full source rate
  assign hi_len = DIV_W'((({1'b0, divide_in} + (DIV_W+1)'(2)) >> 1));

  //////////////////////////////////////////////////////////////////////////
  // divider next state
  always_comb begin
    cnt_nxt = cnt_r;
    clk_nxt = clk_r;
    started_nxt = started_r;
    if (!enable_in) begin
      cnt_nxt = '0;
      clk_nxt = 1'b0;
      started_nxt = 1'b0;
    end else if (src_tick_in) begin
      if (!started_r) begin
        // first source edge after enable drives the clock high
        started_nxt = 1'b1;
        cnt_nxt = '0;
      end else if (cnt_r == divide_in) begin
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + DIV_W'(1);
      end
      clk_nxt = (cnt_nxt < hi_len); // period of divide + 1 ticks
    end
    rise_nxt = clk_nxt & ~clk_r;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
      started_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
      started_r <= started_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign gen_clk_out = clk_r;
  assign gen_rise_out = rise_r;

endmodule : sport_rate_gen

// ==== hdl/sport_ready_event.sv ====
// ready flags, interrupt and dma request logic of a synchronous audio port
// assumes pins are asynchronous to clk_sys_in and much slower than it
`include "sport_map.svh"

// Functional notes
// - generated clock goes high on next source edge, period divide plus one
// - spurious sync error shows within two bit clocks; disable clears it
// - late-released transmitter starts shifting only on the next sync
// - mode 00b makes the interrupt follow the ready flag
// - mode 10b interrupts on each frame sync while section enabled
// - mode 11b interrupts on sync error; flag always readable
// - rx ready sets on buffer copy, clears on data register read
// - rx ready is zero at reset and while receiver disabled
// - rx ready drives rx dma request and mode 00b interrupt
// - transmitter enable rising sets tx ready
// - tx write clears ready, copy to shifter sets it, writes always taken
// - tx ready drives tx dma request and mode 00b interrupt
// - rx and tx interrupts kept separate, one line per controller
module sport_ready_event #(
  parameter int ELEM_BITS = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [31:0] bus_rdata_out,
  input wire logic tx_bit_clock_in,
  output logic tx_bit_clock_out,
  output logic tx_bit_clock_oe_out,
  input wire logic rx_bit_clock_in,
  output logic rx_bit_clock_out,
  output logic rx_bit_clock_oe_out,
  input wire logic tx_frame_sync_in,
  input wire logic rx_frame_sync_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  input wire logic generator_source_clock_in,
  output logic rx_irq_a_out,
  output logic rx_irq_b_out,
  output logic tx_irq_a_out,
  output logic tx_irq_b_out,
  output logic rx_dma_request_out,
  output logic tx_dma_request_out
);

  localparam int CNT_W = $clog2(ELEM_BITS);
  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(ELEM_BITS - 2);
  localparam int NPIN = 6;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage a feeds only stage b
  logic [NPIN-1:0] pin_raw, sync_a_r, sync_b_r, sync_c_r, pin_rise;

  assign pin_raw = {generator_source_clock_in, serial_data_in, rx_frame_sync_in,
                    tx_frame_sync_in, rx_bit_clock_in, tx_bit_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sync_a_r[gi] <= 1'b0;
          sync_b_r[gi] <= 1'b0;
          sync_c_r[gi] <= 1'b0;
        end else begin
          sync_a_r[gi] <= pin_raw[gi];
          sync_b_r[gi] <= sync_a_r[gi];
          sync_c_r[gi] <= sync_b_r[gi];
        end
      end
      assign pin_rise[gi] = sync_b_r[gi] & ~sync_c_r[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // control state and register port
  logic rx_en_r, rx_en_nxt, tx_en_r, tx_en_nxt;
  logic gen_en_r, gen_en_nxt, master_r, master_nxt;
  logic src_sel_r, src_sel_nxt;
  logic [7:0] div_r, div_nxt;
  sport_pkg::irq_mode_type rx_mode_r, rx_mode_nxt, tx_mode_r, tx_mode_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] rx_data_r, rx_data_nxt, tx_data_r, tx_data_nxt;
  logic rx_rdy_r, rx_rdy_nxt, tx_rdy_r, tx_rdy_nxt;
  logic rx_err_r, rx_err_nxt, tx_err_r, tx_err_nxt;
  logic rx_rd, tx_wr;

  assign rx_rd = bus_rd_in && (bus_addr_in == `SP_OFF_RX_DATA);
  assign tx_wr = bus_wr_in && (bus_addr_in == `SP_OFF_TX_DATA);

  // writes to unmapped or read-only offsets are dropped; reads at unmapped offsets give zero
  always_comb begin
    rx_en_nxt = rx_en_r;
    tx_en_nxt = tx_en_r;
    gen_en_nxt = gen_en_r;
    master_nxt = master_r;
    src_sel_nxt = src_sel_r;
    div_nxt = div_r;
    rx_mode_nxt = rx_mode_r;
    tx_mode_nxt = tx_mode_r;
    rdata_nxt = 32'h0000_0000;
    if (bus_wr_in && bus_addr_in == `SP_OFF_CTRL) begin
      rx_en_nxt = bus_wdata_in[`SP_CTL_RX_EN];
      tx_en_nxt = bus_wdata_in[`SP_CTL_TX_EN];
      gen_en_nxt = bus_wdata_in[`SP_CTL_GEN_EN];
      master_nxt = bus_wdata_in[`SP_CTL_MASTER];
      rx_mode_nxt = sport_pkg::irq_mode_type'(bus_wdata_in[`SP_CTL_RX_MODE]);
      tx_mode_nxt = sport_pkg::irq_mode_type'(bus_wdata_in[`SP_CTL_TX_MODE]);
    end
    if (bus_wr_in && bus_addr_in == `SP_OFF_RATE) begin
      div_nxt = bus_wdata_in[`SP_RATE_DIV];
      src_sel_nxt = bus_wdata_in[`SP_RATE_SRC];
    end
    if (bus_rd_in) begin
      case (bus_addr_in)
        `SP_OFF_RX_DATA: rdata_nxt = rx_data_r;
        `SP_OFF_TX_DATA: rdata_nxt = tx_data_r;
        `SP_OFF_CTRL: begin
          rdata_nxt[`SP_CTL_RX_EN] = rx_en_r;
          rdata_nxt[`SP_CTL_RX_RDY] = rx_rdy_r;
          rdata_nxt[`SP_CTL_RX_ERR] = rx_err_r; // readable in any mode
          rdata_nxt[`SP_CTL_RX_MODE] = rx_mode_r;
          rdata_nxt[`SP_CTL_TX_EN] = tx_en_r;
          rdata_nxt[`SP_CTL_TX_RDY] = tx_rdy_r;
          rdata_nxt[`SP_CTL_TX_ERR] = tx_err_r;
          rdata_nxt[`SP_CTL_TX_MODE] = tx_mode_r;
          rdata_nxt[`SP_CTL_GEN_EN] = gen_en_r;
          rdata_nxt[`SP_CTL_MASTER] = master_r;
        end
        `SP_OFF_RATE: begin
          rdata_nxt[`SP_RATE_DIV] = div_r;
          rdata_nxt[`SP_RATE_SRC] = src_sel_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      gen_en_r <= 1'b0;
      master_r <= 1'b0;
      src_sel_r <= `SP_SRC_RST;
      div_r <= `SP_DIV_RST;
      rx_mode_r <= sport_pkg::IRQ_READY;
      tx_mode_r <= sport_pkg::IRQ_READY;
      rdata_r <= 32'h0000_0000;
    end else begin
      rx_en_r <= rx_en_nxt;
      tx_en_r <= tx_en_nxt;
      gen_en_r <= gen_en_nxt;
      master_r <= master_nxt;
      src_sel_r <= src_sel_nxt;
      div_r <= div_nxt;
      rx_mode_r <= rx_mode_nxt;
      tx_mode_r <= tx_mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bit clock selection and generator
  logic gen_tick, gen_clk, gen_rise, tx_bclk_rise, rx_bclk_rise;

  // source 0 is the bus clock itself, source 1 the synchronised pin
  assign gen_tick = src_sel_r ? pin_rise[5] : 1'b1;
  assign tx_bclk_rise = master_r ? gen_rise : pin_rise[0];
  assign rx_bclk_rise = master_r ? gen_rise : pin_rise[1];

  sport_rate_gen #(
    .DIV_W(8)
  ) u_gen (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .enable_in(gen_en_r),
    .divide_in(div_r),
    .src_tick_in(gen_tick),
    .gen_clk_out(gen_clk),
    .gen_rise_out(gen_rise)
  );

  //////////////////////////////////////////////////////////////////////////
  // transmitter: ready flag, copy into the shifter, sync errors
  sport_pkg::shift_state_type tx_st_r, tx_st_nxt;
  logic [ELEM_BITS-1:0] tx_shift_r, tx_shift_nxt;
  logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
  logic [1:0] tx_settle_r, tx_settle_nxt;
  logic tx_en_d_r, tx_first_r, tx_first_nxt;
  logic tx_fs_prev_r, tx_fs_prev_nxt, tx_fs_pulse;
  logic sdo_r, sdo_nxt;

  // frame sync is taken as a rising level seen at a bit clock rising edge
  assign tx_fs_pulse = tx_bclk_rise & sync_b_r[2] & ~tx_fs_prev_r;

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_shift_nxt = tx_shift_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_settle_nxt = tx_settle_r;
    tx_first_nxt = tx_first_r;
    tx_data_nxt = tx_data_r;
    tx_rdy_nxt = tx_rdy_r;
    tx_err_nxt = tx_err_r;
    sdo_nxt = sdo_r;
    tx_fs_prev_nxt = tx_bclk_rise ? sync_b_r[2] : tx_fs_prev_r;
    // data writes are taken whether or not the shifter is busy
    if (tx_wr) begin
      tx_data_nxt = bus_wdata_in;
    end
    if (!tx_en_r) begin
      tx_st_nxt = sport_pkg::SH_IDLE;
      tx_rdy_nxt = 1'b0;
      tx_err_nxt = 1'b0; // disabling flushes a pending sync error
      tx_cnt_nxt = '0;
      tx_settle_nxt = 2'h0;
      sdo_nxt = 1'b0;
    end else begin
      if (!tx_en_d_r) begin
        tx_rdy_nxt = 1'b1; // enable edge: data register free
        if (!tx_first_r) begin
          tx_settle_nxt = `SP_SETTLE_BCLK;
          tx_first_nxt = 1'b1;
        end
      end
      if (tx_wr) begin
        tx_rdy_nxt = 1'b0;
      end
      if (tx_bclk_rise) begin
        if (tx_settle_r != 2'h0) begin
          // only the first enable after reset has this settling window
          tx_settle_nxt = tx_settle_r - 2'h1;
          if (tx_fs_pulse) begin
            tx_err_nxt = 1'b1;
          end
        end else if (tx_fs_pulse && tx_st_r == sport_pkg::SH_BUSY) begin
          tx_err_nxt = 1'b1; // sync inside an element
        end else if (tx_fs_pulse) begin
          // shifting waits for a sync after enable
          tx_st_nxt = sport_pkg::SH_BUSY;
          tx_cnt_nxt = '0;
          if (!tx_rdy_r) begin
            tx_shift_nxt = tx_data_r[ELEM_BITS-1:0];
            tx_rdy_nxt = !tx_wr; // copy sets; a same-cycle write stays pending
          end
          sdo_nxt = tx_shift_nxt[ELEM_BITS-1];
        end else if (tx_st_r == sport_pkg::SH_BUSY) begin
          tx_shift_nxt = {tx_shift_r[ELEM_BITS-2:0], 1'b0};
          sdo_nxt = tx_shift_r[ELEM_BITS-2];
          tx_cnt_nxt = tx_cnt_r + CNT_W'(1);
          if (tx_cnt_r == LAST_CNT) begin
            tx_st_nxt = sport_pkg::SH_IDLE;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_r <= sport_pkg::SH_IDLE;
      tx_shift_r <= '0;
      tx_cnt_r <= '0;
      tx_settle_r <= 2'h0;
      tx_en_d_r <= 1'b0;
      tx_first_r <= 1'b0;
      tx_fs_prev_r <= 1'b0;
      tx_data_r <= 32'h0000_0000;
      tx_rdy_r <= 1'b0;
      tx_err_r <= 1'b0;
      sdo_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_shift_r <= tx_shift_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_settle_r <= tx_settle_nxt;
      tx_en_d_r <= tx_en_r;
      tx_first_r <= tx_first_nxt;
      tx_fs_prev_r <= tx_fs_prev_nxt;
      tx_data_r <= tx_data_nxt;
      tx_rdy_r <= tx_rdy_nxt;
      tx_err_r <= tx_err_nxt;
      sdo_r <= sdo_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receiver: shifter, one-word buffer, data register and ready flag
  sport_pkg::shift_state_type rx_st_r, rx_st_nxt;
  logic [ELEM_BITS-1:0] rx_shift_r, rx_shift_nxt, rx_buf_r, rx_buf_nxt;
  logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
  logic rx_full_r, rx_full_nxt, rx_fs_prev_r, rx_fs_prev_nxt, rx_fs_pulse;

  assign rx_fs_pulse = rx_bclk_rise & sync_b_r[3] & ~rx_fs_prev_r;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_shift_nxt = rx_shift_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_buf_nxt = rx_buf_r;
    rx_full_nxt = rx_full_r;
    rx_data_nxt = rx_data_r;
    rx_rdy_nxt = rx_rdy_r;
    rx_err_nxt = rx_err_r;
    rx_fs_prev_nxt = rx_bclk_rise ? sync_b_r[3] : rx_fs_prev_r;
    if (rx_rd) begin
      rx_rdy_nxt = 1'b0; // read empties the data register
    end
    if (!rx_en_r) begin
      rx_st_nxt = sport_pkg::SH_IDLE;
      rx_cnt_nxt = '0;
      rx_full_nxt = 1'b0;
      rx_rdy_nxt = 1'b0; // nothing pending while disabled
      rx_err_nxt = 1'b0;
    end else begin
      if (rx_full_r && !rx_rdy_r) begin
        // copy beats a same-cycle read so the new word is not lost
        rx_data_nxt = {{(32-ELEM_BITS){1'b0}}, rx_buf_r};
        rx_rdy_nxt = 1'b1;
        rx_full_nxt = 1'b0;
      end
      if (rx_bclk_rise) begin
        if (rx_fs_pulse && rx_st_r == sport_pkg::SH_BUSY) begin
          rx_err_nxt = 1'b1; // sync inside an element
        end
        if (rx_fs_pulse || rx_st_r == sport_pkg::SH_BUSY) begin
          rx_shift_nxt = {rx_shift_r[ELEM_BITS-2:0], sync_b_r[4]};
          rx_cnt_nxt = rx_fs_pulse ? '0 : rx_cnt_r + CNT_W'(1);
          rx_st_nxt = sport_pkg::SH_BUSY;
          if (!rx_fs_pulse && rx_cnt_r == LAST_CNT) begin
            // a full buffer is overwritten: overrun keeps the newest word
            rx_buf_nxt = rx_shift_nxt;
            rx_full_nxt = 1'b1;
            rx_st_nxt = sport_pkg::SH_IDLE;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_r <= sport_pkg::SH_IDLE;
      rx_shift_r <= '0;
      rx_cnt_r <= '0;
      rx_buf_r <= '0;
      rx_full_r <= 1'b0;
      rx_fs_prev_r <= 1'b0;
      rx_data_r <= 32'h0000_0000;
      rx_rdy_r <= 1'b0;
      rx_err_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_full_r <= rx_full_nxt;
      rx_fs_prev_r <= rx_fs_prev_nxt;
      rx_data_r <= rx_data_nxt;
      rx_rdy_r <= rx_rdy_nxt;
      rx_err_r <= rx_err_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts, dma requests and bit clock pin drive
  logic rx_irq_nxt, tx_irq_nxt;
  logic rx_irq_a_r, rx_irq_b_r, tx_irq_a_r, tx_irq_b_r;
  logic rx_dma_r, tx_dma_r, bclk_out_r, bclk_oe_r;

  always_comb begin
    case (rx_mode_r)
      sport_pkg::IRQ_READY: rx_irq_nxt = rx_rdy_nxt;
      sport_pkg::IRQ_FSYNC: rx_irq_nxt = rx_fs_pulse & rx_en_r;
      sport_pkg::IRQ_SYNCERR: rx_irq_nxt = rx_err_nxt & ~rx_err_r;
      default: rx_irq_nxt = 1'b0;
    endcase
    case (tx_mode_r)
      sport_pkg::IRQ_READY: tx_irq_nxt = tx_rdy_nxt;
      sport_pkg::IRQ_FSYNC: tx_irq_nxt = tx_fs_pulse & tx_en_r;
      sport_pkg::IRQ_SYNCERR: tx_irq_nxt = tx_err_nxt & ~tx_err_r;
      default: tx_irq_nxt = 1'b0;
    endcase
  end

  // each interrupt gets its own line to each controller
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_irq_a_r <= 1'b0;
      rx_irq_b_r <= 1'b0;
      tx_irq_a_r <= 1'b0;
      tx_irq_b_r <= 1'b0;
      rx_dma_r <= 1'b0;
      tx_dma_r <= 1'b0;
      bclk_out_r <= 1'b0;
      bclk_oe_r <= 1'b0;
    end else begin
      rx_irq_a_r <= rx_irq_nxt;
      rx_irq_b_r <= rx_irq_nxt;
      tx_irq_a_r <= tx_irq_nxt;
      tx_irq_b_r <= tx_irq_nxt;
      rx_dma_r <= rx_rdy_nxt;
      tx_dma_r <= tx_rdy_nxt;
      bclk_out_r <= gen_clk;
      bclk_oe_r <= master_r;
    end
  end

  assign bus_rdata_out = rdata_r;
  assign rx_irq_a_out = rx_irq_a_r;
  assign rx_irq_b_out = rx_irq_b_r;
  assign tx_irq_a_out = tx_irq_a_r;
  assign tx_irq_b_out = tx_irq_b_r;
  assign rx_dma_request_out = rx_dma_r;
  assign tx_dma_request_out = tx_dma_r;
  assign serial_data_out = sdo_r;
  assign tx_bit_clock_out = bclk_out_r;
  assign rx_bit_clock_out = bclk_out_r;
  assign tx_bit_clock_oe_out = bclk_oe_r;
  assign rx_bit_clock_oe_out = bclk_oe_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  AST_GEN_FIRST_HIGH: assert property ($rose(gen_en_r) && !src_sel_r |=> gen_clk)
    else $error("generated clock not high after enable");
  AST_TX_ERR_FLUSH: assert property (!tx_en_r |=> !tx_err_r ##1 !tx_err_r || tx_en_r)
    else $error("tx sync error survives disable");
  AST_IRQ_FOLLOWS_RDY: assert property (rx_mode_r == sport_pkg::IRQ_READY
    && $stable(rx_mode_r) |-> rx_irq_a_r == rx_rdy_r)
    else $error("rx irq does not follow ready");
  AST_FS_IRQ: assert property (tx_mode_r == sport_pkg::IRQ_FSYNC && tx_fs_pulse
    && tx_en_r |=> tx_irq_a_r && tx_irq_b_r)
    else $error("tx frame sync irq missing");
  AST_ERR_IRQ: assert property (rx_mode_r == sport_pkg::IRQ_SYNCERR
    |=> rx_irq_a_r == (rx_err_r && !$past(rx_err_r)))
    else $error("rx sync error irq wrong");
  AST_RX_COPY: assert property (rx_en_r && rx_full_r && !rx_rdy_r
    |=> rx_rdy_r && rx_data_r[ELEM_BITS-1:0] == $past(rx_buf_r))
    else $error("rx copy did not set ready");
  AST_RX_READ_CLR: assert property (rx_rd && !rx_full_r |=> !rx_rdy_r)
    else $error("rx read did not clear ready");
  AST_RX_OFF: assert property (!rx_en_r |=> !rx_rdy_r && !rx_dma_r)
    else $error("rx ready set while disabled");
  AST_TX_EN_RDY: assert property ($rose(tx_en_r) && !tx_wr |=> tx_rdy_r)
    else $error("tx enable did not set ready");
  AST_TX_WR_CLR: assert property (tx_wr && tx_en_r |=> !tx_rdy_r
    && tx_data_r == $past(bus_wdata_in))
    else $error("tx write not taken");
  AST_DMA_TRACK: assert property (tx_dma_r == tx_rdy_r && rx_dma_r == rx_rdy_r)
    else $error("dma request differs from ready");

endmodule : sport_ready_event

// ==== tb/sport_far_end.sv ====
// far-end serial device: bit clock and frame sync master, one element a frame
// assumes go_in pulses only while no frame is running
////////////////////////////////////////////////////////////
module sport_far_end #(
  parameter int BITS = 16,
  parameter int HALF_NS = 24
) (
  input wire logic go_in,
  input wire logic [BITS-1:0] word_in,
  output logic bclk_out,
  output logic fs_out,
  output logic sd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels before the first frame
  initial begin
    bclk_out = 1'b0;
    fs_out = 1'b0;
    sd_out = 1'b0;
  end
  // sync on the first bit, msb first; clock stands still between frames
  always @(posedge go_in) begin
    for (int i = 0; i < BITS; i++) begin
      fs_out = (i == 0);
      sd_out = word_in[BITS-1-i];
      #HALF_NS bclk_out = 1'b1;
      #HALF_NS bclk_out = 1'b0;
    end
    fs_out = 1'b0;
    // released line shows the inverse so a stale bit never passes
    sd_out = ~sd_out;
  end
endmodule : sport_far_end

// ==== tb/tb.sv ====
// bench for the ready, irq and dma logic, far end as external frame master
// assumes the map header is on the include path
`include "sport_map.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
////////////////////////////////////////////////////////////
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic go = 1'b0;
  logic [15:0] word = 16'h0;
  logic [15:0] cap = 16'h0;
  logic [31:0] rdata, d;
  logic tx_out, tx_oe, rx_out, rx_oe, bclk, fs, sd, sdo;
  logic rx_a, rx_b, tx_a, tx_b, rx_dma, tx_dma;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int ab_diff = 0;
  int hi = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  sport_far_end #(.BITS(16), .HALF_NS(24)) u_sport_far_end (
    .go_in(go), .word_in(word), .bclk_out(bclk), .fs_out(fs), .sd_out(sd));
  // pin level: the design drives it while its enable is high
  sport_ready_event #(.ELEM_BITS(16)) u_sport_ready_event (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bus_addr_in(addr),
    .bus_wdata_in(wdata), .bus_wr_in(wr_s), .bus_rd_in(rd_s), .bus_rdata_out(rdata),
    .tx_bit_clock_in(tx_oe ? tx_out : bclk), .tx_bit_clock_out(tx_out),
    .tx_bit_clock_oe_out(tx_oe), .rx_bit_clock_in(rx_oe ? rx_out : bclk),
    .rx_bit_clock_out(rx_out), .rx_bit_clock_oe_out(rx_oe), .tx_frame_sync_in(fs),
    .rx_frame_sync_in(fs), .serial_data_in(sd), .serial_data_out(sdo),
    .generator_source_clock_in(1'b0), .rx_irq_a_out(rx_a), .rx_irq_b_out(rx_b),
    .tx_irq_a_out(tx_a), .tx_irq_b_out(tx_b), .rx_dma_request_out(rx_dma),
    .tx_dma_request_out(tx_dma));
  // timeout, irq cycle counts, and a check that the two irq copies agree
  always @(posedge clk_sys_in) begin
    cycles++;
    rx_cnt += rx_a;
    tx_cnt += tx_a;
    ab_diff += (rx_a !== rx_b) || (tx_a !== tx_b);
    if (cycles == 6000) begin
      num_errors++;
      complete_run();
    end
  end
  // data pin sampled mid bit, far from the tick where it changes
  always @(negedge bclk) cap <= {cap[14:0], sdo};
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk_sys_in);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // one frame from the far end; the wait covers a whole element
  task automatic frame(input logic [15:0] w);
    @(posedge clk_sys_in);
    word <= w;
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    repeat (220) @(posedge clk_sys_in);
  endtask : frame
  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(`SP_OFF_CTRL);
    `CHK("ctrl_rst", 32'h0, d)
    rd(`SP_OFF_RATE);
    `CHK("rate_rst", 32'h1, d)
    rd(8'h30);
    `CHK("unmapped", 32'h0, d)
    `CHK("rx_dma_rst", 1'b0, rx_dma)
    // first tx enable: a sync in the settle window flags an error
    wr(`SP_OFF_CTRL, 32'h0001_0000);
    frame(16'h0);
    rd(`SP_OFF_CTRL);
    `CHK("settle", 32'h000B_0000, d)
    `CHK("tx_dma_en", 1'b1, tx_dma)
    `CHK("tx_irq_en", 1'b1, tx_a)
    wr(`SP_OFF_CTRL, 32'h0);
    rd(`SP_OFF_CTRL);
    `CHK("flush", 32'h0, d)
    // both sections on, tx word queued before the next sync arrives
    wr(`SP_OFF_CTRL, 32'h0001_0001);
    wr(`SP_OFF_TX_DATA, 32'hA5C3);
    @(posedge clk_sys_in);
    #1;
    `CHK("tx_dma_wr", 1'b0, tx_dma)
    frame(16'h3C5A);
    `CHK("sdo", 16'hA5C3, cap)
    `CHK("tx_copy", 1'b1, tx_dma)
    `CHK("rx_dma", 1'b1, rx_dma)
    `CHK("rx_irq", 1'b1, rx_a)
    rd(`SP_OFF_RX_DATA);
    `CHK("rx_data", 32'h3C5A, d)
    repeat (2) @(posedge clk_sys_in);
    #1;
    `CHK("rx_clr", 1'b0, rx_dma)
    // rx irq per sync only; tx irq no longer follows its ready flag
    wr(`SP_OFF_CTRL, 32'h0031_0021);
    // the old mode's irq level still stands for one cycle after the write
    @(posedge clk_sys_in);
    #1 rx_cnt = 0;
    tx_cnt = 0;
    frame(16'h0F0F);
    `CHK("rx_fs_irq", 1, rx_cnt)
    `CHK("tx_err_irq", 0, tx_cnt)
    // receiver disabled: ready dropped, no sync interrupt; tx irq per sync
    wr(`SP_OFF_CTRL, 32'h0021_0020);
    @(posedge clk_sys_in);
    #1 rx_cnt = 0;
    tx_cnt = 0;
    frame(16'h1234);
    `CHK("rx_off_dma", 1'b0, rx_dma)
    `CHK("rx_off_irq", 0, rx_cnt)
    `CHK("tx_fs_irq", 1, tx_cnt)
    // generator from the bus clock, divide 3: period 4, high 2
    wr(`SP_OFF_CTRL, 32'h0);
    wr(`SP_OFF_RATE, 32'h3);
    repeat (2) @(posedge clk_sys_in);
    wr(`SP_OFF_CTRL, 32'h0140_0000);
    repeat (2) @(posedge clk_sys_in);
    #1;
    `CHK("gen_first", 1'b1, tx_out)
    `CHK("gen_oe", 1'b1, tx_oe)
    `CHK("gen_rx_pin", 2'b11, {rx_out, rx_oe})
    hi = 0;
    repeat (40) begin
      @(posedge clk_sys_in);
      #1 hi += tx_out;
    end
    `CHK("gen_high", 20, hi)
    // second reset mid-run: the next first tx enable has a settle window again
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    `CHK("rst_out", 7'h0, {tx_out, tx_oe, rx_a, tx_a, rx_dma, tx_dma, sdo})
    wr(`SP_OFF_CTRL, 32'h0031_0031);
    @(posedge clk_sys_in);
    #1 rx_cnt = 0;
    tx_cnt = 0;
    frame(16'h00FF);
    `CHK("tx_err_irq_rst", 1, tx_cnt)
    `CHK("rx_err_irq", 0, rx_cnt)
    rd(`SP_OFF_CTRL);
    `CHK("settle_rst", 32'h003B_0033, d)
    `CHK("irq_pair", 0, ab_diff)
    complete_run();
  end
endmodule : tb
